// file: common/ted_pkg.sv
// Purpose: shared constants for the errored-frame end delimiter coder
// Assumes: one clock; symbols leave one group per accepted line step
// Notes: symbol kinds are abstract codes handed to the ternary mapper
package ted_pkg;
    // symbol group kinds on the line side
    localparam logic [2:0] SYM_IDLE = 3'h0; // idle group
    localparam logic [2:0] SYM_DATA = 3'h1; // data group carrying a nibble
    localparam logic [2:0] SYM_ESD1 = 3'h2; // first end delimiter
    localparam logic [2:0] SYM_ESD2 = 3'h3; // second end delimiter
    localparam logic [2:0] SYM_ESD3 = 3'h4; // ordinary third end delimiter
    localparam logic [2:0] SYM_ERR_ESD3 = 3'h5; // error-marked third delimiter
    // buffer entry layout: {is_end, err, nibble}
    localparam int ENT_W = 6; // entry width
    localparam int ENT_END = 5; // end-of-frame marker bit
    localparam int ENT_ERR = 4; // frame carried an error
    localparam int FIFO_DEPTH = 32; // buffer depth in entries
    localparam int FIFO_AW = 5; // index width
    // values after reset
    localparam logic [3:0] RST_DATA = 4'h0; // line data nibble
    localparam logic [3:0] IDLE_NIBBLE = 4'h0; // nibble value between frames
    // line control states
    typedef enum logic [2:0] {
        st_idle, st_esd1, st_esd2, st_esd3,
        st_err_esd1, st_err_esd2, st_err_esd3
    } ted_state_type;
endpackage : ted_pkg

// file: hdl/ted_fifo.sv
// Purpose: flip-flop buffer between nibble intake and line coder
// Assumes: single clock, asynchronous active-high reset
// Notes: in_ready is a registered not-full flag
`timescale 1ns/1ns
module ted_fifo #(
    parameter int WIDTH = ted_pkg::ENT_W,
    parameter int DEPTH = ted_pkg::FIFO_DEPTH,
    parameter int AW = ted_pkg::FIFO_AW
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic in_valid, // push request
    output logic in_ready, // room for a push
    input wire logic [WIDTH-1:0] in_data, // pushed word
    output logic out_valid, // a word is waiting
    input wire logic out_ready, // drain takes the word
    output logic [WIDTH-1:0] out_data // oldest word
);
    logic [WIDTH-1:0] mem [DEPTH]; // storage
    logic [AW-1:0] wr_idx; // write index
    logic [AW-1:0] rd_idx; // read index
    logic [AW:0] count; // words held
    logic push; // accepted push
    logic pop; // accepted pop

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data = mem[rd_idx];

    // one storage word per entry
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_ent
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
                mem[i] <= '0;
            else if (push && wr_idx == AW'(i))
                mem[i] <= in_data;
        end
    end

    // indices wrap at the power-of-two depth
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_idx <= '0;
            rd_idx <= '0;
        end
        else
        begin
            if (push)
                wr_idx <= wr_idx + 1'b1;
            if (pop)
                rd_idx <= rd_idx + 1'b1;
        end
    end

    // occupancy and registered not-full
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            if (push && !pop)
            begin
                count <= count + 1'b1;
                in_ready <= (count != (AW+1)'(DEPTH - 1));
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
                in_ready <= 1'b1;
            end
        end
    end
endmodule : ted_fifo

// file: hdl/ted_tx.sv
// Purpose: transmit end-of-frame coder with error delimiter sequence
// Assumes: nibble inputs synchronous to clk; line side paces by sym_step
// Notes: one symbol group per step; delimiter run is never cut short
// Behaviour
// - error ESD1 sent, then error ESD2 next
// - error ESD2 sent, then error-marked ESD3 next
// - error-marked ESD3 sent, then idle follows
// - delimiter states ignore nibble, enable, error inputs
// - errored frame ends ESD1, ESD2, error ESD3
// - frame one cycle later waits full sequence
// - any frame length, including 5, 6, 8
// - clean frame ends ESD1, ESD2, ESD3, idle
`timescale 1ns/1ns
module ted_tx (
    input wire logic clk, // 100 MHz clock
    input wire logic rst, // async reset, high
    input wire logic [3:0] txd, // transmit nibble
    input wire logic tx_en, // transmit enable
    input wire logic tx_er, // transmit error
    output logic tx_ready, // buffer has room
    input wire logic sym_step, // line takes one group
    output logic [2:0] sym_kind, // group kind
    output logic [3:0] sym_data // nibble of a data group
);
    ted_pkg::ted_state_type state; // line control state
    logic in_frame; // a frame is open on intake
    logic frame_err; // error seen in open frame
    logic push_valid; // intake offers an entry
    logic [ted_pkg::ENT_W-1:0] push_data; // offered entry
    logic head_valid; // buffered entry waiting
    logic [ted_pkg::ENT_W-1:0] head; // oldest entry
    logic take; // line coder pops now
    logic head_end; // oldest entry ends a frame
    logic head_err; // that frame was errored

    // intake: data while enabled, one end marker after the frame
    always_comb
    begin
        push_valid = 1'b0;
        push_data = '0;
        if (tx_en)
        begin
            push_valid = 1'b1;
            push_data = {1'b0, 1'b0, txd};
        end
        else if (in_frame)
        begin
            push_valid = 1'b1;
            push_data = {1'b1, frame_err, ted_pkg::IDLE_NIBBLE};
        end
    end

    // frame open flag; end marker waits for room if needed
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            in_frame <= 1'b0;
        else if (tx_en)
            in_frame <= 1'b1;
        else if (in_frame && tx_ready)
            in_frame <= 1'b0;
    end

    // error latch: set wins, cleared with the end marker
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            frame_err <= 1'b0;
        else if (tx_en && tx_er)
            frame_err <= 1'b1;
        else if (in_frame && !tx_en && tx_ready)
            frame_err <= 1'b0;
    end

    ted_fifo #(
        .WIDTH(ted_pkg::ENT_W),
        .DEPTH(ted_pkg::FIFO_DEPTH),
        .AW(ted_pkg::FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_valid),
        .in_ready(tx_ready),
        .in_data(push_data),
        .out_valid(head_valid),
        .out_ready(take),
        .out_data(head)
    );

    assign head_end = head[ted_pkg::ENT_END];
    assign head_err = head[ted_pkg::ENT_ERR];
    // only the idle/data state reads the buffer; later frames wait there
    assign take = sym_step && head_valid && (state == ted_pkg::st_idle);

    // line control: each step in a delimiter state advances exactly one state; idle/data moves only on a taken end marker
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= ted_pkg::st_idle;
        else if (sym_step)
        begin
            case (state)
                ted_pkg::st_idle:
                begin
                    if (take && head_end && head_err)
                        state <= ted_pkg::st_err_esd1;
                    else if (take && head_end)
                        state <= ted_pkg::st_esd1;
                end
                ted_pkg::st_esd1:
                    state <= ted_pkg::st_esd2;
                ted_pkg::st_esd2:
                    state <= ted_pkg::st_esd3;
                ted_pkg::st_err_esd1:
                    state <= ted_pkg::st_err_esd2;
                ted_pkg::st_err_esd2:
                    state <= ted_pkg::st_err_esd3;
                default:
                    state <= ted_pkg::st_idle;
            endcase
        end
    end

    // group output, registered with the state it belongs to
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sym_kind <= ted_pkg::SYM_IDLE;
            sym_data <= ted_pkg::RST_DATA;
        end
        else if (sym_step)
        begin
            sym_data <= ted_pkg::RST_DATA;
            case (state)
                ted_pkg::st_idle:
                begin
                    if (take && head_end)
                        sym_kind <= ted_pkg::SYM_ESD1;
                    else if (take)
                    begin
                        sym_kind <= ted_pkg::SYM_DATA;
                        sym_data <= head[3:0];
                    end
                    else
                        sym_kind <= ted_pkg::SYM_IDLE;
                end
                ted_pkg::st_esd1, ted_pkg::st_err_esd1:
                    sym_kind <= ted_pkg::SYM_ESD2;
                ted_pkg::st_esd2:
                    sym_kind <= ted_pkg::SYM_ESD3;
                ted_pkg::st_err_esd2:
                    sym_kind <= ted_pkg::SYM_ERR_ESD3;
                default:
                    sym_kind <= ted_pkg::SYM_IDLE;
            endcase
        end
    end

    // checks on the delimiter sequence and the frame error latch
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_err_entry;
        take && head_end && head_err;
    endsequence

    sequence s_err_tail;
        state == ted_pkg::st_err_esd2 && sym_kind == ted_pkg::SYM_ESD2;
    endsequence

    a_err_esd1_entry: assert property (s_err_entry |=>
        state == ted_pkg::st_err_esd1 && sym_kind == ted_pkg::SYM_ESD1)
        else $error("errored end did not start with ESD1");

    a_err_esd1_next: assert property (
        state == ted_pkg::st_err_esd1 && sym_step |=> s_err_tail)
        else $error("ESD1 not followed by ESD2");

    a_err_esd2_next: assert property (
        state == ted_pkg::st_err_esd2 && sym_step |=>
        state == ted_pkg::st_err_esd3 && sym_kind == ted_pkg::SYM_ERR_ESD3)
        else $error("ESD2 not followed by error ESD3");

    a_err_esd3_idle: assert property (
        state == ted_pkg::st_err_esd3 && sym_step |=>
        state == ted_pkg::st_idle && sym_kind == ted_pkg::SYM_IDLE)
        else $error("error ESD3 not followed by idle");

    a_err_run_whole: assert property (
        s_err_entry ##1 sym_step [*3] |=>
        sym_kind == ted_pkg::SYM_IDLE && $past(sym_kind) == ted_pkg::SYM_ERR_ESD3
        && $past(sym_kind, 2) == ted_pkg::SYM_ESD2)
        else $error("error delimiter run altered");

    a_err_hold_stall: assert property (
        state != ted_pkg::st_idle && !sym_step |=> $stable(state) && $stable(sym_kind))
        else $error("delimiter moved without a step");

    a_plain_esd3: assert property (
        state == ted_pkg::st_esd2 && sym_step |=> sym_kind == ted_pkg::SYM_ESD3)
        else $error("clean frame lacks ordinary ESD3");

    a_err_latched: assert property (
        tx_en && tx_er |=> frame_err)
        else $error("frame error not recorded");

    a_new_frame_wait: assert property (
        state != ted_pkg::st_idle |=> sym_kind != ted_pkg::SYM_DATA)
        else $error("data group during delimiter run");
endmodule : ted_tx

// file: sim/ted_mac_model.sv
// Purpose: controller model that drives the nibble intake
// Assumes: one clock; signals change just after a rising edge
// Notes: idle nibbles with enable and error low between frames
`timescale 1ns/1ns
module ted_mac_model (
    input wire logic clk, // system clock
    output logic [3:0] txd, // transmit nibble
    output logic tx_en, // transmit enable
    output logic tx_er // transmit error
);
    // idle condition from time zero
    initial
    begin
        txd = ted_pkg::IDLE_NIBBLE;
        tx_en = 1'b0;
        tx_er = 1'b0;
    end
    // one frame of len nibbles counting up from nib, then gap idle cycles
    task automatic send(input int len, input logic err, input logic [3:0] nib, input int gap);
        for (int i = 0; i < len; i++)
        begin
            @(posedge clk);
            txd <= nib + 4'(i);
            tx_en <= 1'b1;
            tx_er <= err;
        end
        @(posedge clk);
        txd <= ted_pkg::IDLE_NIBBLE;
        tx_en <= 1'b0;
        tx_er <= 1'b0;
        repeat (gap - 1) @(posedge clk);
    endtask : send
endmodule : ted_mac_model

// file: sim/test_pcs_tx_error_end_delimiter.sv
// Purpose: self-checking bench for the end delimiter coder
// Assumes: line side paced by sym_step, driven at rising edges
// Notes: each non-idle line step, and the idle after a third delimiter, is checked against a queue of expected groups
`timescale 1ns/1ns
module test_pcs_tx_error_end_delimiter;
    logic clk = 1'b0; // system clock
    logic rst = 1'b1; // async reset
    logic sym_step = 1'b1; // line pacing
    logic [3:0] txd; // nibble from model
    logic tx_en; // enable from model
    logic tx_er; // error from model
    logic tx_ready; // buffer room
    logic [2:0] sym_kind; // group kind
    logic [3:0] sym_data; // group nibble
    int bad_count = 0; // mismatches
    int cmp_count = 0; // comparisons
    logic [6:0] exp_q[$]; // expected {kind, data}
    logic [6:0] want; // next expected group
    logic [2:0] prev_kind = ted_pkg::SYM_IDLE; // kind of last step
    logic st; // step seen at this edge
    typedef struct {int len; logic err; logic [3:0] nib; int gap; logic [2:0] last;} ted_row_type;
    // frames: errored 5, 6, 8 long, gaps of one to three cycles, one clean frame
    ted_row_type rows[6] = '{'{6, 1'b1, 4'h5, 2, ted_pkg::SYM_ERR_ESD3},
        '{5, 1'b1, 4'h5, 1, ted_pkg::SYM_ERR_ESD3},
        '{6, 1'b1, 4'h5, 1, ted_pkg::SYM_ERR_ESD3},
        '{5, 1'b1, 4'h5, 2, ted_pkg::SYM_ERR_ESD3},
        '{8, 1'b1, 4'h5, 3, ted_pkg::SYM_ERR_ESD3},
        '{8, 1'b0, 4'h5, 3, ted_pkg::SYM_ESD3}};
    always #5 clk = ~clk;
    ted_tx uut (.clk(clk), .rst(rst), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
        .tx_ready(tx_ready), .sym_step(sym_step), .sym_kind(sym_kind), .sym_data(sym_data));
    ted_mac_model mac (.clk(clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er));
    // compare and count
    task chk(input logic [6:0] seen, input logic [6:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // queue n data groups, the three delimiters, then one idle
    task expect_frame(input int n, input logic [3:0] nib, input logic [2:0] last);
        for (int i = 0; i < n; i++)
            exp_q.push_back({ted_pkg::SYM_DATA, nib + 4'(i)});
        exp_q.push_back({ted_pkg::SYM_ESD1, 4'h0});
        exp_q.push_back({ted_pkg::SYM_ESD2, 4'h0});
        exp_q.push_back({last, 4'h0});
        exp_q.push_back({ted_pkg::SYM_IDLE, 4'h0});
    endtask : expect_frame
    // wait until every expected group went out
    task drain;
        for (int k = 0; k < 300 && exp_q.size() != 0; k++)
            @(posedge clk);
        chk(7'(exp_q.size()), 7'h0);
    endtask : drain
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // line monitor: non-idle groups and the idle after a third delimiter
    always @(posedge clk)
    begin
        st = sym_step;
        #1;
        if (!rst && st && (sym_kind !== ted_pkg::SYM_IDLE || prev_kind >= ted_pkg::SYM_ESD3))
        begin
            want = (exp_q.size() != 0) ? exp_q.pop_front() : 7'h7f;
            chk({sym_kind, sym_data}, want);
        end
        if (st)
            prev_kind = sym_kind;
    end
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        chk({sym_kind, sym_data}, {ted_pkg::SYM_IDLE, ted_pkg::RST_DATA});
        chk(7'(tx_ready), 7'h1);
        rst <= 1'b0;
        // table of frames, inputs change during the delimiters
        foreach (rows[r])
        begin
            expect_frame(rows[r].len, rows[r].nib, rows[r].last);
            mac.send(rows[r].len, rows[r].err, rows[r].nib, rows[r].gap);
        end
        drain;
        // stalled line: 34 nibbles offered, only 32 fit
        sym_step <= 1'b0;
        expect_frame(32, 4'h0, ted_pkg::SYM_ERR_ESD3);
        mac.send(34, 1'b1, 4'h0, 2);
        @(negedge clk);
        chk(7'(tx_ready), 7'h0);
        chk({sym_kind, sym_data}, 7'h0);
        @(posedge clk);
        sym_step <= 1'b1;
        drain;
        @(negedge clk);
        chk(7'(tx_ready), 7'h1);
        // reset in mid-run with a full buffer and an errored end pending
        @(posedge clk);
        sym_step <= 1'b0;
        mac.send(34, 1'b1, 4'h9, 2);
        rst <= 1'b1;
        @(negedge clk);
        chk(7'(tx_ready), 7'h1);
        chk({sym_kind, sym_data}, 7'h0);
        @(posedge clk);
        rst <= 1'b0;
        sym_step <= 1'b1;
        // clean frame on a line that steps every other cycle; old entries must be gone
        expect_frame(5, 4'h5, ted_pkg::SYM_ESD3);
        fork
            mac.send(5, 1'b0, 4'h5, 2);
            repeat (30) @(posedge clk) sym_step <= !sym_step;
        join
        @(posedge clk);
        sym_step <= 1'b1;
        drain;
        test_done;
    end
    // watchdog against a hang
    initial
    begin
        #100000;
        bad_count++;
        test_done;
    end
endmodule : test_pcs_tx_error_end_delimiter
